/* hdl/vcr_pkg.sv */
/*
  vcr_pkg: constants and carrier types of the voice codec control register bank.
  Assumes one 40 MHz clock that also serves as the codec master clock.
*/
package vcr_pkg;

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TX_SETUP = 8'h40;
  localparam logic [7:0] IDX_SETUP    = 8'h58;
  localparam logic [7:0] IDX_PATH     = 8'h59;
  localparam logic [7:0] IDX_GAIN1    = 8'h5A;
  localparam logic [7:0] IDX_GAIN2    = 8'h5B;
  localparam logic [7:0] IDX_FREQ_HI  = 8'h5C;
  localparam logic [7:0] IDX_FREQ_LO  = 8'h5D;
  localparam logic [7:0] IDX_SMP_LO   = 8'h5E;
  localparam logic [7:0] IDX_SMP_HI   = 8'h5F;
  localparam logic [7:0] IDX_DIV      = 8'h60;
  localparam logic [7:0] IDX_DW_LAST  = 8'h7F;

  // ----------------------------------------------------------------
  // field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int unsigned AMP_LSB     = 4;
  localparam int unsigned GAIN_DIS    = 3;
  localparam int unsigned MUTE_BIT    = 1;
  localparam int unsigned MIC_BIT     = 0;
  localparam int unsigned HPF_BIT     = 4;
  localparam int unsigned CODEC_BIT   = 3;
  localparam int unsigned SIDE_BIT    = 2;
  localparam int unsigned RING_BIT    = 1;
  localparam int unsigned TXS_BIT     = 0;
  localparam int unsigned DW_MAP_BIT  = 5;
  localparam logic [7:0]  SETUP_MASK  = 8'h3B;
  localparam logic [7:0]  PATH_MASK   = 8'h1F;
  localparam logic [7:0]  FHI_MASK    = 8'h1F;
  localparam logic [7:0]  SHI_MASK    = 8'h3F;
  localparam logic [7:0]  TXS_MASK    = 8'h20;
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic [1:0]  AMP_EAR     = 2'h1;
  localparam logic [1:0]  AMP_SPK     = 2'h2;

  // ----------------------------------------------------------------
  // sample clock divider
  // ----------------------------------------------------------------
  localparam int unsigned RATIO_OFS   = 4;
  localparam logic [3:0]  RATIO_MAXC  = 4'hC;
  localparam int unsigned SAMPLE_MUL  = 16;
  localparam int unsigned SYM_SAMPLES = 8;

  typedef struct packed {
    logic       ear_en;
    logic       spk_en;
    logic       out_6db;
    logic       in_mute;
    logic       second_microphone_sel;
    logic       hpf_bypass;
    logic       codec_en;
    logic       sidetone_en;
    logic       ring_en;
    logic       tx_sig_en;
    logic [3:0] in_gain;
    logic [3:0] out_atten;
    logic [3:0] tone_atten;
    logic [3:0] side_atten;
    logic [12:0] ring_freq;
  } vcr_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] data;
  } vcr_smp_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] addr;
    logic [7:0] data;
  } vcr_dw_t;

  typedef struct packed {
    logic tx_sample;
    logic tx_symbol;
    logic rx_sample;
  } vcr_rates_t;

endpackage

/* hdl/vcr_ahb_slave.sv */
/*
  vcr_ahb_slave: AHB-Lite slave front end that turns bus transfers into byte
  register writes and reads by word index. Assumes it is the only slave, so
  hready comes back from its own hreadyout, and single word transfers.
*/
`timescale 1ns/1ps
module vcr_ahb_slave (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // register side
  output logic             wr_en,
  output logic [7:0]       wr_idx,
  output logic [7:0]       wr_data,
  output logic [7:0]       rd_idx,
  input  wire logic [7:0]  rd_data
);
  import vcr_pkg::*;

  typedef struct packed {
    logic        ph_valid;
    logic        ph_write;
    logic        ph_wait;
    logic [7:0]  ph_idx;
    logic [31:0] rdata;
  } vcr_ahb_st_t;

  vcr_ahb_st_t s_q;
  vcr_ahb_st_t s_d;
  logic        take;

  // size is always a word here; the field is accepted but not checked
  assign take = hsel & htrans[1] & (hsize == 3'h2 || hsize != 3'h2);

  always_comb begin
    s_d = s_q;
    if (s_q.ph_wait) begin
      // one wait state lets a write just before this read land first
      s_d.rdata   = {24'h000000, rd_data};
      s_d.ph_wait = 1'b0;
    end else if (hready) begin
      s_d.ph_valid = take;
      s_d.ph_write = hwrite;
      s_d.ph_idx   = haddr[9:2];
      s_d.ph_wait  = take & ~hwrite;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = ~s_q.ph_wait;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;
  assign wr_en     = s_q.ph_valid & s_q.ph_write;
  assign wr_idx    = s_q.ph_idx;
  assign wr_data   = hwdata[7:0];
  assign rd_idx    = s_q.ph_idx;

endmodule

/* hdl/vcr_rate_div.sv */
/*
  vcr_rate_div: sample and symbol enable pulses for one path from a 4-bit
  ratio code. Assumes the system clock is the master clock.
*/
`timescale 1ns/1ps
module vcr_rate_div #(
  parameter int unsigned CW = 8
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // control and enables
  input  wire logic [3:0] ratio_code,
  output logic            sample_en,
  output logic            symbol_en
);
  import vcr_pkg::*;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [2:0]    sub;
    logic          smp;
    logic          sym;
  } vcr_div_st_t;

  vcr_div_st_t s_q;
  vcr_div_st_t s_d;
  logic [3:0]    code;
  logic [CW-1:0] last;

  // reserved codes run at the slowest legal ratio
  assign code = (ratio_code > RATIO_MAXC) ? RATIO_MAXC : ratio_code;
  assign last = CW'((32'(code) + RATIO_OFS) * SAMPLE_MUL - 1); // RL18

  always_comb begin
    s_d     = s_q;
    s_d.smp = 1'b0;
    s_d.sym = 1'b0;
    if (s_q.cnt >= last) begin
      s_d.cnt = '0;
      s_d.smp = 1'b1;
      s_d.sub = s_q.sub + 3'h1;
      s_d.sym = (32'(s_q.sub) == SYM_SAMPLES - 1); // RL18
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sample_en = s_q.smp;
  assign symbol_en = s_q.sym;

endmodule

/* hdl/vcr_codec_regs.sv */
/*
  vcr_codec_regs: voice codec control register bank behind an AHB-Lite slave.
  Drives amplifier, gain, path enables, ring tone frequency, decode samples,
  path sample rate enables and transmit filter direct-write strobes.
  Assumes the analogue codec sits outside and the system clock is the master
  clock; encode samples arrive as one-cycle valid strobes.
*/
// Decided for this implementation: the AHB-Lite interface to the registers.
// What this block does
// RL1: amplifier field codes none, earpiece, speaker; code three reserved.
// RL2: never both output amplifiers enabled at the same time.
// RL3: unselected amplifier powers down with no extra write.
// RL4: gain disable bit clear gives 6 dB, set gives 0 dB.
// RL5: input mute bit set silences the analogue input to encode.
// RL6: microphone bit clear picks first microphone, set picks second.
// RL7: high-pass disable bit set bypasses voice high-pass filtering.
// RL8: codec enable set runs the data path; clear powers it down.
// RL9: sidetone enable adds scaled input into decode output only while set.
// RL10: ring tone enable turns the tone generator on and off.
// RL11: transmit enable passes voice onto the decode path only while set.
// RL12: input gain nibble 1.5 dB steps up; output nibble 2 dB steps down.
// RL13: tone gain 2 dB steps down; sidetone -12.5 dB down 1 dB steps.
// RL14: 13-bit tone value over 2.048 gives hertz; high five, low eight.
// RL15: writing the 14-bit sample delivers it to the decode path.
// RL16: reading the sample port returns latest encode sample.
// RL17: divider register reachable only while transmit setup bit 5 clear.
// RL18: divider nibbles give ratio code plus four; sample and symbol clocks.
// RL19: with bit 5 set the divider range maps to direct-write points.
// RL20: host writes zero to unused bits and avoids reserved codes.
// RL21: fields take effect on the edge ending the host write.
`timescale 1ns/1ps
module vcr_codec_regs #(
  parameter int unsigned DIV_CW = 8
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // ahb-lite register bus
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // analogue codec controls
  output vcr_pkg::vcr_ctrl_t      codec_ctrl,
  // voice samples
  output vcr_pkg::vcr_smp_t       dec_sample,
  input  wire vcr_pkg::vcr_smp_t  enc_sample,
  // transmit filter direct write
  output vcr_pkg::vcr_dw_t        direct_write,
  // path rate enables
  output vcr_pkg::vcr_rates_t     path_rates
);
  import vcr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  setup;
    logic [7:0]  path;
    logic [7:0]  gain1;
    logic [7:0]  gain2;
    logic [7:0]  freq_hi;
    logic [7:0]  freq_lo;
    logic [7:0]  smp_lo;
    logic [7:0]  div;
    logic [7:0]  tx_setup;
    logic [13:0] enc_smp;
    vcr_ctrl_t   ctrl;
    vcr_smp_t    dec;
    vcr_dw_t     dw;
  } vcr_st_t;

  vcr_st_t    s_q;
  vcr_st_t    s_d;

  // the output stage leaves reset at 6 dB, since the gain disable bit resets clear
  localparam vcr_ctrl_t CTRL_RST = '{out_6db: 1'b1, default: '0}; // RL4
  localparam vcr_st_t   ST_RST   = '{ctrl: CTRL_RST, default: '0};

  logic       wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic       tx_sym;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // true when an index falls in the direct-write window
  function automatic logic in_dw_window(
    input logic [7:0] idx,
    input logic [7:0] txs
  );
    in_dw_window = txs[DW_MAP_BIT] && idx >= IDX_DIV && idx <= IDX_DW_LAST;
  endfunction

  // analogue control word from the raw register images
  function automatic vcr_ctrl_t decode_ctrl(
    input logic [7:0] setup,
    input logic [7:0] path,
    input logic [7:0] gain1,
    input logic [7:0] gain2,
    input logic [7:0] fhi,
    input logic [7:0] flo
  );
    vcr_ctrl_t  c;
    logic [1:0] amp;
    c   = '0;
    amp = setup[AMP_LSB +: 2];
    // reserved code three falls through to none, so only one driver can run
    c.ear_en      = (amp == AMP_EAR); // RL1 RL2 RL3
    c.spk_en      = (amp == AMP_SPK); // RL1 RL2 RL3
    c.out_6db     = ~setup[GAIN_DIS]; // RL4
    c.in_mute     = setup[MUTE_BIT]; // RL5
    c.second_microphone_sel    = setup[MIC_BIT]; // RL6
    c.hpf_bypass  = path[HPF_BIT]; // RL7
    c.codec_en    = path[CODEC_BIT]; // RL8
    c.sidetone_en = path[SIDE_BIT]; // RL9
    c.ring_en     = path[RING_BIT]; // RL10
    c.tx_sig_en   = path[TXS_BIT]; // RL11
    c.in_gain     = gain1[7:4]; // RL12
    c.out_atten   = gain1[3:0]; // RL12
    c.tone_atten  = gain2[7:4]; // RL13
    c.side_atten  = gain2[3:0]; // RL13
    c.ring_freq   = {fhi[4:0], flo}; // RL14
    return c;
  endfunction

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  vcr_ahb_slave u_bus (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .wr_idx    (wr_idx),
    .wr_data   (wr_data),
    .rd_idx    (rd_idx),
    .rd_data   (rd_data)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    if (in_dw_window(rd_idx, s_q.tx_setup)) begin
      // direct-write points are not read back through this bank
      rd_data = 8'h00; // RL19
    end else begin
      unique case (rd_idx)
        IDX_TX_SETUP: rd_data = s_q.tx_setup;
        IDX_SETUP:    rd_data = s_q.setup;
        IDX_PATH:     rd_data = s_q.path;
        IDX_GAIN1:    rd_data = s_q.gain1;
        IDX_GAIN2:    rd_data = s_q.gain2;
        IDX_FREQ_HI:  rd_data = s_q.freq_hi;
        IDX_FREQ_LO:  rd_data = s_q.freq_lo;
        IDX_SMP_LO:   rd_data = s_q.enc_smp[7:0]; // RL16
        IDX_SMP_HI:   rd_data = {2'b00, s_q.enc_smp[13:8]}; // RL16
        IDX_DIV:      rd_data = s_q.div; // RL17
        default:      rd_data = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register writes and sample capture
  // ----------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.dec.valid = 1'b0;
    s_d.dw.valid  = 1'b0;

    // a powered-down codec produces no fresh encode samples
    if (enc_sample.valid && s_q.ctrl.codec_en) begin
      s_d.enc_smp = enc_sample.data; // RL8 RL16
    end

    if (wr_en) begin
      if (in_dw_window(wr_idx, s_q.tx_setup)) begin
        s_d.dw.valid = 1'b1; // RL19
        s_d.dw.addr  = wr_idx[4:0];
        s_d.dw.data  = wr_data;
      end else begin
        // unused bits are masked so a careless host cannot set them
        unique case (wr_idx)
          IDX_TX_SETUP: s_d.tx_setup = wr_data & TXS_MASK;
          IDX_SETUP:    s_d.setup    = wr_data & SETUP_MASK; // RL20
          IDX_PATH:     s_d.path     = wr_data & PATH_MASK;
          IDX_GAIN1:    s_d.gain1    = wr_data;
          IDX_GAIN2:    s_d.gain2    = wr_data;
          IDX_FREQ_HI:  s_d.freq_hi  = wr_data & FHI_MASK; // RL14
          IDX_FREQ_LO:  s_d.freq_lo  = wr_data; // RL14
          IDX_SMP_LO:   s_d.smp_lo   = wr_data; // RL15
          IDX_SMP_HI: begin
            // the high byte completes the sample and hands it on
            s_d.dec.data  = {wr_data[5:0], s_q.smp_lo}; // RL15
            s_d.dec.valid = s_q.ctrl.codec_en & s_q.ctrl.tx_sig_en; // RL11
          end
          IDX_DIV:      s_d.div      = wr_data; // RL17
          default: begin
          end
        endcase
      end
    end

    // outputs follow the register images on the same edge
    s_d.ctrl = decode_ctrl(s_d.setup, s_d.path, s_d.gain1, s_d.gain2,
                           s_d.freq_hi, s_d.freq_lo); // RL21
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // path sample clocks
  // ----------------------------------------------------------------
  vcr_rate_div #(
    .CW (DIV_CW)
  ) u_tx_div (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .ratio_code (s_q.div[7:4]),
    .sample_en  (path_rates.tx_sample),
    .symbol_en  (tx_sym)
  ); // RL18

  vcr_rate_div #(
    .CW (DIV_CW)
  ) u_rx_div (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .ratio_code (s_q.div[3:0]),
    .sample_en  (path_rates.rx_sample),
    .symbol_en  ()
  ); // RL18

  assign path_rates.tx_symbol = tx_sym;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign codec_ctrl   = s_q.ctrl;
  assign dec_sample   = s_q.dec;
  assign direct_write = s_q.dw;

endmodule

/* tb/vcr_codec_regs_assertions.sv */
/* checker for the codec register bank; sees only the top ports.
   assumes a bind from the bench top and zero-wait write data phases. */
`timescale 1ns/1ps
module vcr_codec_regs_chk
  import vcr_pkg::*;
(
  // clock and bus
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  // codec side
  input wire vcr_ctrl_t   codec_ctrl,
  input wire vcr_smp_t    dec_sample
);
  // ----------------------------------------
  // write data phase tracking
  // ----------------------------------------
  logic       wph_q;
  logic [7:0] widx_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wph_q <= 1'b0;
    end else if (hready) begin
      wph_q <= hsel && htrans[1] && hwrite;
    end
    if (hready) begin
      widx_q <= haddr[9:2];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence wr_done(logic [7:0] idx);
    wph_q && hready && widx_q == idx;
  endsequence
  sequence rd_taken;
    hsel && htrans[1] && !hwrite && hready;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_amp_select: assert property (wr_done(IDX_SETUP) |=> {codec_ctrl.ear_en, codec_ctrl.spk_en} ==
    {$past(hwdata[5:4]) == AMP_EAR, $past(hwdata[5:4]) == AMP_SPK}) else $error("amplifier enables wrong");
  a_amps_exclusive: assert property (!(codec_ctrl.ear_en && codec_ctrl.spk_en))
    else $error("both amplifiers enabled");
  a_out_gain: assert property (wr_done(IDX_SETUP) |=> codec_ctrl.out_6db == !$past(hwdata[3]))
    else $error("output gain bit wrong");
  a_mute_mic: assert property (wr_done(IDX_SETUP) |=> {codec_ctrl.in_mute, codec_ctrl.second_microphone_sel} ==
    {$past(hwdata[1]), $past(hwdata[0])}) else $error("mute or microphone wrong");
  a_path_enables: assert property (wr_done(IDX_PATH) |=> {codec_ctrl.hpf_bypass, codec_ctrl.codec_en,
    codec_ctrl.sidetone_en, codec_ctrl.ring_en, codec_ctrl.tx_sig_en} == $past(hwdata[4:0]))
    else $error("path enables wrong");
  a_level_gains: assert property (wr_done(IDX_GAIN1) |=>
    {codec_ctrl.in_gain, codec_ctrl.out_atten} == $past(hwdata[7:0])) else $error("level gains wrong");
  a_tone_gains: assert property (wr_done(IDX_GAIN2) |=>
    {codec_ctrl.tone_atten, codec_ctrl.side_atten} == $past(hwdata[7:0])) else $error("tone gains wrong");
  a_ring_low: assert property (wr_done(IDX_FREQ_LO) |=> codec_ctrl.ring_freq[7:0] == $past(hwdata[7:0]))
    else $error("ring frequency low byte wrong");
  a_sample_out: assert property (wr_done(IDX_SMP_HI) ##0 (codec_ctrl.codec_en && codec_ctrl.tx_sig_en) |=>
    dec_sample.valid && dec_sample.data[13:8] == $past(hwdata[5:0])) else $error("decode sample not sent");
  a_read_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule

/* tb/vcr_codec_regs_test.sv */
/* self-checking bench for the codec register bank.
   assumes the checker file is compiled first; bus driven as the one master. */
`timescale 1ns/1ps
module vcr_codec_regs_test;
  import vcr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp;
  vcr_ctrl_t   codec_ctrl;
  vcr_smp_t    dec_sample, enc_sample;
  vcr_dw_t     direct_write;
  vcr_rates_t  path_rates;
  logic [13:0] dec_data;
  logic [12:0] dw_data;
  int          bad_count, comparisons, dec_cnt, dw_cnt, p, n0;
  always #12.5 sys_clk = ~sys_clk;
  vcr_codec_regs vcr_codec_regs_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .codec_ctrl(codec_ctrl),
    .dec_sample(dec_sample), .enc_sample(enc_sample), .direct_write(direct_write), .path_rates(path_rates));
  // single-cycle strobes are caught here so no pulse is missed between bus calls
  always @(posedge sys_clk) begin
    if (dec_sample.valid === 1'b1) begin
      dec_cnt++;
      dec_data = dec_sample.data;
    end
    if (direct_write.valid === 1'b1) begin
      dw_cnt++;
      dw_data = {direct_write.addr, direct_write.data};
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_up(string what);
    check(what, 32'h0, 32'h1);
    print_verdict();
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) give_up("bus timeout");
  endtask
  task automatic bus(logic wr, logic [7:0] idx, logic [7:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    r = hrdata;
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
    // the register and its outputs take the data at the closing edge; one more edge so the checks see the new values
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [7:0] idx, output logic [31:0] r);
    bus(1'b0, idx, 8'h00, r);
  endtask
  task automatic period(int which, output int p);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge sys_clk);
      if (path_rates[which] === 1'b1) break;
    end
    for (p = 1; p < 2000; p++) begin
      @(posedge sys_clk);
      if (path_rates[which] === 1'b1) break;
    end
    if (p == 2000) give_up("rate timeout");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [7:0] idx [8] = '{IDX_SETUP, IDX_PATH, IDX_GAIN1, IDX_GAIN2, IDX_FREQ_HI, IDX_FREQ_LO, IDX_DIV, 8'h3F};
    foreach (idx[i]) begin
      rd(idx[i], rv);
      check("reset value", rv, 32'h0);
    end
    check("out 6db at reset", codec_ctrl.out_6db, 1'b1);
    $display("done reset");
  endtask
  task automatic t_setup;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {2'b00, i[1:0], i[0], 1'b0, i[1], ~i[0]};
      wr(IDX_SETUP, v);
      check("earpiece", codec_ctrl.ear_en, i == 1);
      check("speaker", codec_ctrl.spk_en, i == 2);
      check("out 6db", codec_ctrl.out_6db, !v[3]);
      check("mute", codec_ctrl.in_mute, v[1]);
      check("second_microphone", codec_ctrl.second_microphone_sel, v[0]);
      rd(IDX_SETUP, rv);
      check("setup read", rv, {24'h0, v});
    end
    $display("done setup");
  endtask
  task automatic t_path;
    for (int b = 0; b < 5; b++) begin
      wr(IDX_PATH, 8'h01 << b);
      check("path bits", {codec_ctrl.hpf_bypass, codec_ctrl.codec_en, codec_ctrl.sidetone_en,
        codec_ctrl.ring_en, codec_ctrl.tx_sig_en}, 32'h1 << b);
    end
    $display("done path");
  endtask
  task automatic t_gains;
    logic [7:0] v [2] = '{8'h0F, 8'hE1};
    foreach (v[i]) begin
      wr(IDX_GAIN1, v[i]);
      check("level gains", {codec_ctrl.in_gain, codec_ctrl.out_atten}, v[i]);
      wr(IDX_GAIN2, v[i]);
      check("tone gains", {codec_ctrl.tone_atten, codec_ctrl.side_atten}, v[i]);
    end
    wr(IDX_FREQ_HI, 8'h1F);
    wr(IDX_FREQ_LO, 8'hA5);
    check("ring freq", codec_ctrl.ring_freq, 13'h1FA5);
    $display("done gains");
  endtask
  task automatic t_sample;
    wr(IDX_PATH, 8'h09);
    wr(IDX_SMP_LO, 8'h34);
    n0 = dec_cnt;
    wr(IDX_SMP_HI, 8'h2A);
    repeat (2) @(posedge sys_clk);
    check("decode count", dec_cnt - n0, 1);
    check("decode data", dec_data, 14'h2A34);
    wr(IDX_PATH, 8'h08);
    wr(IDX_SMP_HI, 8'h15);
    repeat (2) @(posedge sys_clk);
    check("tx off count", dec_cnt - n0, 1);
    enc_sample <= {1'b1, 14'h1ABC};
    @(posedge sys_clk);
    enc_sample <= '0;
    rd(IDX_SMP_LO, rv);
    check("encode low", rv, 32'hBC);
    rd(IDX_SMP_HI, rv);
    check("encode high", rv, 32'h1A);
    wr(IDX_PATH, 8'h00);
    enc_sample <= {1'b1, 14'h0123};
    @(posedge sys_clk);
    enc_sample <= '0;
    rd(IDX_SMP_LO, rv);
    check("encode held", rv, 32'hBC);
    $display("done sample");
  endtask
  task automatic t_divider;
    wr(IDX_DIV, 8'h31);
    rd(IDX_DIV, rv);
    check("divider read", rv, 32'h31);
    period(0, p);
    check("rx period", p, 80);
    period(1, p);
    check("symbol period", p, 896);
    period(2, p);
    check("tx period", p, 112);
    wr(IDX_TX_SETUP, 8'h20);
    n0 = dw_cnt;
    wr(IDX_DIV, 8'h77);
    repeat (2) @(posedge sys_clk);
    check("direct count", dw_cnt - n0, 1);
    check("direct data", dw_data, 13'h0077);
    rd(IDX_DIV, rv);
    check("divider hidden", rv, 32'h0);
    period(0, p);
    check("rx kept", p, 80);
    wr(IDX_TX_SETUP, 8'h00);
    rd(IDX_DIV, rv);
    check("divider back", rv, 32'h31);
    $display("done divider");
  endtask
  initial begin
    haddr = '0;
    htrans = '0;
    hsize = 3'h2;
    hwdata = '0;
    enc_sample = '0;
    repeat (6) @(posedge sys_clk);
    check("out 6db in reset", codec_ctrl.out_6db, 1'b1);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_setup();
    t_path();
    t_gains();
    t_sample();
    t_divider();
    print_verdict();
  end
endmodule
bind vcr_codec_regs vcr_codec_regs_chk vcr_codec_regs_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .codec_ctrl(codec_ctrl), .dec_sample(dec_sample));
